/* File: sbm_pkg.sv */
// package for the slave sap buffer manager
// assumes a wishbone classic slave interface with 32-bit data
package sbm_pkg;
	localparam logic [7:0] SBM_ADR_CTRL = 8'h00;
	localparam logic [7:0] SBM_ADR_STATUS = 8'h04;
	localparam logic [7:0] SBM_ADR_SSA_PTR = 8'h08;
	localparam logic [7:0] SBM_ADR_BUFCMD = 8'h0C;
	localparam logic [7:0] SBM_ADR_DOUT = 8'h10;
	localparam logic [7:0] SBM_ADR_DIN = 8'h14;
	localparam logic [7:0] SBM_ADR_SAPEN = 8'h18;
	localparam logic [7:0] SBM_ADR_TGM = 8'h1C;
	localparam logic [7:0] SBM_ADR_AUX_SEL = 8'h2A;
	localparam logic [7:0] SBM_ADR_ADDR = 8'h20;
	localparam int SBM_CTRL_EN_BIT = 0;
	localparam int SBM_CTRL_RAM4K_BIT = 1;
	localparam logic [2:0] SBM_AUX_SEL_RST = 3'h0;
	localparam logic [7:0] SBM_SSA_PTR_RST = 8'h00;
	localparam int SBM_SHIFT_4K = 4;
	localparam int SBM_SHIFT_2K = 3;
	localparam int SBM_NUM_SAP = 10;
	// sap enable bit positions
	localparam int SBM_SAP_DEF = 0;
	localparam int SBM_SAP_53 = 1;
	localparam int SBM_SAP_55 = 2;
	localparam int SBM_SAP_56 = 3;
	localparam int SBM_SAP_57 = 4;
	localparam int SBM_SAP_58 = 5;
	localparam int SBM_SAP_59 = 6;
	localparam int SBM_SAP_60 = 7;
	localparam int SBM_SAP_61 = 8;
	localparam int SBM_SAP_62 = 9;
	// telegram kinds for staging
	localparam logic [1:0] SBM_TGM_PRM = 2'h0;
	localparam logic [1:0] SBM_TGM_CFG = 2'h1;
	localparam logic [1:0] SBM_TGM_SSA = 2'h2;
	typedef enum logic [1:0] {
		SBM_WAIT_PRM = 2'b00,
		SBM_WAIT_CFG = 2'b01,
		SBM_CYCLIC_EXCHANGE_STATE = 2'b10
	} sbm_dp_state_type;
endpackage

/* File: sbm_rot3.sv */
// three-way rotating buffer index set (transfer, user, next/free)
// assumes single-cycle request pulses from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module sbm_rot3
	import sbm_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// requests
	input wire logic xfer_done_in,
	input wire logic user_take_in,
	// indices
	output logic [1:0] d_idx_out,
	output logic [1:0] u_idx_out,
	output logic [1:0] nf_idx_out,
	output logic next_valid_out
);
	// producer side fills d; on done, d becomes next, free becomes d
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			d_idx_out <= 2'h0;
			u_idx_out <= 2'h1;
			nf_idx_out <= 2'h2;
			next_valid_out <= 1'b0;
		end else if (xfer_done_in) begin
			d_idx_out <= nf_idx_out;
			nf_idx_out <= d_idx_out;
			next_valid_out <= 1'b1;
		end else if (user_take_in && next_valid_out) begin
			u_idx_out <= nf_idx_out;
			nf_idx_out <= u_idx_out;
			next_valid_out <= 1'b0;
		end
	end
	a_rot_distinct: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(d_idx_out != u_idx_out) && (u_idx_out != nf_idx_out) && (d_idx_out != nf_idx_out))
		else $error("rotating indices collide");
	a_rot_next: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		xfer_done_in |=> next_valid_out && (nf_idx_out == $past(d_idx_out)))
		else $error("done did not publish next buffer");
endmodule
`default_nettype wire

/* File: sbm_top.sv */
// slave sap buffer manager: sap gating, buffer rotation, aux staging, address forming
// assumes a wishbone classic master and a protocol engine on the same clock
`timescale 1ns/100ps
`default_nettype none
module sbm_top
	import sbm_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// protocol engine events
	input wire logic TGM_END_IN,
	input wire logic TGM_OK_IN,
	input wire logic [1:0] TGM_KIND_IN,
	input wire logic [7:0] TGM_LEN_IN,
	input wire logic [7:0] AUX1_LEN_IN,
	input wire logic [7:0] AUX2_LEN_IN,
	input wire logic DOUT_DONE_IN,
	input wire logic DIN_DONE_IN,
	input wire logic DIAG_SENT_IN,
	input wire logic GO_CYCLIC_EXCHANGE_STATE_IN,
	input wire logic GO_WAIT_PRM_IN,
	// outputs to engine
	output logic [9:0] SAP_EN_OUT,
	output logic NO_RES_OUT,
	output logic [1:0] DP_STATE_OUT,
	output logic [1:0] RD_IN_IDX_OUT,
	output logic [1:0] RD_OUT_IDX_OUT,
	output logic DIAG_DEV_IDX_OUT,
	output logic [11:0] RAM_ADDR_OUT
);
	logic ctrl_en_r;
	logic ram4k_r;
	logic [2:0] aux_sel_r;
	logic [7:0] ssa_ptr_r;
	logic [7:0] seg_r;
	logic [7:0] off_r;
	logic prm_aux2_r;
	logic cfg_aux2_r;
	logic ssa_aux2_r;
	logic diag_swap_pend_r;
	logic diag_dev_r;
	sbm_dp_state_type dp_state_r;
	logic [9:0] sap_en_nxt;
	logic wb_req;
	logic wb_wr;
	logic dout_take;
	logic din_take;
	logic [1:0] dout_d, dout_u, dout_nf, din_d, din_u, din_nf;
	logic dout_nv, din_nv;
	logic aux_is2;
	logic [7:0] aux_len;
	logic fits;
	logic [11:0] addr_nxt;

	assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
	assign wb_wr = wb_req && WB_WE_IN && WB_SEL_IN[0];
	assign dout_take = wb_wr && (WB_ADR_IN == SBM_ADR_BUFCMD) && WB_DAT_IN[0];
	assign din_take = wb_wr && (WB_ADR_IN == SBM_ADR_BUFCMD) && WB_DAT_IN[1];

	// bus acknowledge one cycle after request
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WB_ACK_OUT <= 1'b0;
		end else begin
			WB_ACK_OUT <= wb_req;
		end
	end

	// control register
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_en_r <= 1'b0;
			ram4k_r <= 1'b0;
		end else if (wb_wr && WB_ADR_IN == SBM_ADR_CTRL) begin
			ctrl_en_r <= WB_DAT_IN[SBM_CTRL_EN_BIT];
			ram4k_r <= WB_DAT_IN[SBM_CTRL_RAM4K_BIT];
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			aux_sel_r <= SBM_AUX_SEL_RST;
		end else if (wb_wr && WB_ADR_IN == SBM_ADR_AUX_SEL) begin
			aux_sel_r <= WB_DAT_IN[2:0];
		end
	end

	// address-change pointer
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ssa_ptr_r <= SBM_SSA_PTR_RST;
		end else if (wb_wr && WB_ADR_IN == SBM_ADR_SSA_PTR) begin
			ssa_ptr_r <= WB_DAT_IN[7:0];
		end
	end

	// segment and offset for address forming
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			seg_r <= 8'h00;
			off_r <= 8'h00;
		end else if (wb_wr && WB_ADR_IN == SBM_ADR_ADDR) begin
			seg_r <= WB_DAT_IN[7:0];
			off_r <= (WB_SEL_IN[1]) ? WB_DAT_IN[15:8] : off_r;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			dp_state_r <= SBM_WAIT_PRM;
		end else if (!ctrl_en_r || GO_WAIT_PRM_IN) begin
			dp_state_r <= SBM_WAIT_PRM;
		end else begin
			case (dp_state_r)
				SBM_WAIT_PRM: begin
					if (TGM_END_IN && TGM_OK_IN && fits && TGM_KIND_IN == SBM_TGM_PRM)
						dp_state_r <= SBM_WAIT_CFG;
				end
				SBM_WAIT_CFG: begin
					if (GO_CYCLIC_EXCHANGE_STATE_IN)
						dp_state_r <= SBM_CYCLIC_EXCHANGE_STATE;
				end
				SBM_CYCLIC_EXCHANGE_STATE: begin
					dp_state_r <= SBM_CYCLIC_EXCHANGE_STATE;
				end
				default: begin
					dp_state_r <= SBM_WAIT_PRM;
				end
			endcase
		end
	end

	// data saps gated by exchange state
	always_comb begin
		sap_en_nxt = '0;
		if (ctrl_en_r) begin
			sap_en_nxt[SBM_SAP_53] = 1'b1;
			sap_en_nxt[SBM_SAP_55] = (ssa_ptr_r != 8'h00);
			sap_en_nxt[SBM_SAP_59] = 1'b1;
			sap_en_nxt[SBM_SAP_60] = 1'b1;
			sap_en_nxt[SBM_SAP_61] = 1'b1;
			sap_en_nxt[SBM_SAP_62] = 1'b1;
			if (dp_state_r == SBM_CYCLIC_EXCHANGE_STATE) begin
				sap_en_nxt[SBM_SAP_DEF] = 1'b1;
				sap_en_nxt[SBM_SAP_56] = 1'b1;
				sap_en_nxt[SBM_SAP_57] = 1'b1;
				sap_en_nxt[SBM_SAP_58] = 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			SAP_EN_OUT <= '0;
		end else begin
			SAP_EN_OUT <= sap_en_nxt;
		end
	end

	// aux buffer choice per telegram kind
	always_comb begin
		case (TGM_KIND_IN)
			SBM_TGM_PRM: aux_is2 = aux_sel_r[0];
			SBM_TGM_CFG: aux_is2 = aux_sel_r[1];
			SBM_TGM_SSA: aux_is2 = aux_sel_r[2];
			default: aux_is2 = 1'b0;
		endcase
	end
	assign aux_len = aux_is2 ? AUX2_LEN_IN : AUX1_LEN_IN;
	assign fits = (TGM_LEN_IN <= aux_len);

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			NO_RES_OUT <= 1'b0;
		end else begin
			NO_RES_OUT <= TGM_END_IN && !fits;
		end
	end
	a_no_res_pulse: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(TGM_END_IN && (TGM_LEN_IN > aux_len)) |=> NO_RES_OUT)
		else $error("oversize telegram without no-resources reply");

	// swap aux with target on good telegram
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			prm_aux2_r <= 1'b0;
			cfg_aux2_r <= 1'b0;
			ssa_aux2_r <= 1'b0;
		end else if (TGM_END_IN && TGM_OK_IN && fits) begin
			case (TGM_KIND_IN)
				SBM_TGM_PRM: prm_aux2_r <= !prm_aux2_r;
				SBM_TGM_CFG: cfg_aux2_r <= !cfg_aux2_r;
				SBM_TGM_SSA: ssa_aux2_r <= !ssa_aux2_r;
				default: prm_aux2_r <= prm_aux2_r;
			endcase
		end
	end
	a_swap_bad_keep: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(TGM_END_IN && !TGM_OK_IN) |=> $stable(prm_aux2_r) && $stable(cfg_aux2_r))
		else $error("bad telegram swapped a buffer");
	a_swap_good: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(TGM_END_IN && TGM_OK_IN && fits && TGM_KIND_IN == SBM_TGM_PRM)
		|=> prm_aux2_r != $past(prm_aux2_r))
		else $error("parameter swap wrong");

	sbm_rot3 u_dout (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.xfer_done_in(DOUT_DONE_IN),
		.user_take_in(dout_take),
		.d_idx_out(dout_d),
		.u_idx_out(dout_u),
		.nf_idx_out(dout_nf),
		.next_valid_out(dout_nv)
	);
	sbm_rot3 u_din (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.xfer_done_in(din_take),
		.user_take_in(DIN_DONE_IN),
		.d_idx_out(din_u),
		.u_idx_out(din_d),
		.nf_idx_out(din_nf),
		.next_valid_out(din_nv)
	);

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RD_IN_IDX_OUT <= 2'h0;
			RD_OUT_IDX_OUT <= 2'h0;
		end else begin
			RD_IN_IDX_OUT <= din_d;
			RD_OUT_IDX_OUT <= dout_u;
		end
	end
	a_rd_roles: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		RST_N_IN |=> RD_IN_IDX_OUT == $past(din_d) && RD_OUT_IDX_OUT == $past(dout_u))
		else $error("read service role mismatch");

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			diag_dev_r <= 1'b0;
			diag_swap_pend_r <= 1'b0;
		end else begin
			if (wb_wr && WB_ADR_IN == SBM_ADR_BUFCMD && WB_DAT_IN[2])
				diag_swap_pend_r <= 1'b1;
			else if (DIAG_SENT_IN)
				diag_swap_pend_r <= 1'b0;
			if (DIAG_SENT_IN && diag_swap_pend_r)
				diag_dev_r <= !diag_dev_r;
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			DIAG_DEV_IDX_OUT <= 1'b0;
			DP_STATE_OUT <= 2'b00;
		end else begin
			DIAG_DEV_IDX_OUT <= diag_dev_r;
			DP_STATE_OUT <= dp_state_r;
		end
	end
	a_state_code: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		DP_STATE_OUT != 2'b11)
		else $error("illegal protocol state code");
	a_sap_gate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(dp_state_r != SBM_CYCLIC_EXCHANGE_STATE) |=> !SAP_EN_OUT[SBM_SAP_56] && !SAP_EN_OUT[SBM_SAP_DEF])
		else $error("data sap enabled outside exchange");
	a_ssa_off: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(ssa_ptr_r == 8'h00) |=> !SAP_EN_OUT[SBM_SAP_55])
		else $error("sap 55 enabled with zero pointer");
	a_reserved_on: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		ctrl_en_r |=> SAP_EN_OUT[SBM_SAP_61] && SAP_EN_OUT[SBM_SAP_53])
		else $error("reserved sap not enabled");

	always_comb begin
		if (ram4k_r)
			addr_nxt = ({4'h0, seg_r} << SBM_SHIFT_4K) + {4'h0, off_r};
		else
			addr_nxt = {1'b0, (({3'h0, seg_r} << SBM_SHIFT_2K) + {3'h0, off_r})};
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RAM_ADDR_OUT <= 12'h000;
		end else begin
			RAM_ADDR_OUT <= addr_nxt;
		end
	end
	a_addr_form: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		ram4k_r |=> RAM_ADDR_OUT == {$past(seg_r), 4'h0} + {4'h0, $past(off_r)})
		else $error("ram address wrong");

	// read mux
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WB_DAT_OUT <= 32'h0000_0000;
		end else if (wb_req && !WB_WE_IN) begin
			case (WB_ADR_IN)
				SBM_ADR_CTRL: WB_DAT_OUT <= {30'h0, ram4k_r, ctrl_en_r};
				SBM_ADR_STATUS: WB_DAT_OUT <= {26'h0, diag_dev_r, din_nv, dout_nv, 1'b0,
					dp_state_r};
				SBM_ADR_SSA_PTR: WB_DAT_OUT <= {24'h0, ssa_ptr_r};
				SBM_ADR_DOUT: WB_DAT_OUT <= {26'h0, dout_nf, dout_u, dout_d};
				SBM_ADR_DIN: WB_DAT_OUT <= {26'h0, din_nf, din_u, din_d};
				SBM_ADR_SAPEN: WB_DAT_OUT <= {22'h0, SAP_EN_OUT};
				SBM_ADR_TGM: WB_DAT_OUT <= {29'h0, ssa_aux2_r, cfg_aux2_r, prm_aux2_r};
				SBM_ADR_AUX_SEL: WB_DAT_OUT <= {29'h0, aux_sel_r};
				SBM_ADR_ADDR: WB_DAT_OUT <= {20'h0, addr_nxt};
				default: WB_DAT_OUT <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: sbm_far_model.sv */
// fieldbus-side model: delivers telegram end events and aux lengths
// assumes the bench calls send() and shares the system clock
`timescale 1ns/100ps
`default_nettype none
module sbm_far_model #(
	parameter logic [7:0] AUX1_LEN = 8'h20,
	parameter logic [7:0] AUX2_LEN = 8'h40
) (
	// clock
	input wire logic clk_in,
	// telegram events
	output logic tgm_end_out,
	output logic tgm_ok_out,
	output logic [1:0] tgm_kind_out,
	output logic [7:0] tgm_len_out,
	// configured aux lengths
	output logic [7:0] aux1_len_out,
	output logic [7:0] aux2_len_out
);
	// buffer sizes fixed, aux1 always there
	assign aux1_len_out = AUX1_LEN;
	assign aux2_len_out = AUX2_LEN;
	initial begin
		tgm_end_out = 1'b0;
		tgm_ok_out = 1'b1;
		tgm_kind_out = 2'h3;
		tgm_len_out = 8'hFF;
	end
	// one telegram end, qualifiers inverted once the pulse is over
	task automatic send(input logic [1:0] k, input logic [7:0] l, input logic ok);
		@(posedge clk_in);
		tgm_end_out <= 1'b1;
		tgm_ok_out <= ok;
		tgm_kind_out <= k;
		tgm_len_out <= l;
		@(posedge clk_in);
		tgm_end_out <= 1'b0;
		tgm_ok_out <= ~ok;
		tgm_kind_out <= ~k;
		tgm_len_out <= ~l;
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the sap buffer manager
// assumes the far-side model and the design share one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb;
	import sbm_pkg::*;
	logic clk, rst_n, cyc, stb, we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q, q2;
	logic ack, te, tok, no_res, diag;
	logic [1:0] tk, st, rin, rout;
	logic [7:0] tl, a1, a2;
	logic [4:0] ev;
	logic [9:0] sap;
	logic [11:0] ram;
	int bad_count, check_count, cycles;
	sbm_far_model sbm_far_model_inst (.clk_in(clk), .tgm_end_out(te), .tgm_ok_out(tok),
		.tgm_kind_out(tk), .tgm_len_out(tl), .aux1_len_out(a1), .aux2_len_out(a2));
	sbm_top sbm_top_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .TGM_END_IN(te), .TGM_OK_IN(tok), .TGM_KIND_IN(tk),
		.TGM_LEN_IN(tl), .AUX1_LEN_IN(a1), .AUX2_LEN_IN(a2), .DOUT_DONE_IN(ev[0]),
		.DIN_DONE_IN(ev[1]), .DIAG_SENT_IN(ev[2]), .GO_CYCLIC_EXCHANGE_STATE_IN(ev[3]),
		.GO_WAIT_PRM_IN(ev[4]), .SAP_EN_OUT(sap), .NO_RES_OUT(no_res), .DP_STATE_OUT(st),
		.RD_IN_IDX_OUT(rin), .RD_OUT_IDX_OUT(rout), .DIAG_DEV_IDX_OUT(diag),
		.RAM_ADDR_OUT(ram));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim;
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= 5'h00;
		repeat (2) @(posedge clk);
	endtask
	function automatic logic distinct(input logic [5:0] v);
		return v[1:0] != v[3:2] && v[1:0] != v[5:4] && v[3:2] != v[5:4]
			&& v[1:0] != 2'h3 && v[3:2] != 2'h3 && v[5:4] != 2'h3;
	endfunction
	task automatic t_regs;
		wb(1'b0, SBM_ADR_AUX_SEL, 32'h0, q);
		chk("aux sel reset", 32'h0, q);
		wb(1'b1, SBM_ADR_AUX_SEL, 32'hFF, q);
		wb(1'b0, SBM_ADR_AUX_SEL, 32'h0, q);
		chk("aux sel upper zero", 32'h7, q);
		wb(1'b0, 8'h40, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		wb(1'b0, SBM_ADR_STATUS, 32'h0, q);
		chk("state after reset", 32'h0, {30'h0, q[1:0]});
		wb(1'b1, SBM_ADR_AUX_SEL, 32'h0, q);
	endtask
	task automatic t_sap;
		wb(1'b1, SBM_ADR_SSA_PTR, 32'h10, q);
		wb(1'b1, SBM_ADR_CTRL, 32'h1, q);
		repeat (2) @(posedge clk);
		chk("sap waiting", 32'h3C6, {22'h0, sap});
		wb(1'b1, SBM_ADR_SSA_PTR, 32'h0, q);
		repeat (2) @(posedge clk);
		chk("sap no addr change", 32'h3C2, {22'h0, sap});
		wb(1'b1, SBM_ADR_SSA_PTR, 32'h10, q);
	endtask
	task automatic t_tgm;
		for (int k = 0; k < 3; k++) begin
			sbm_far_model_inst.send(k[1:0], 8'h21, 1'b1);
			@(posedge clk);
			chk("oversize no res", 32'h1, {31'h0, no_res});
		end
		wb(1'b0, SBM_ADR_TGM, 32'h0, q);
		sbm_far_model_inst.send(SBM_TGM_PRM, 8'h20, 1'b0);
		@(posedge clk);
		chk("fit no res", 32'h0, {31'h0, no_res});
		wb(1'b0, SBM_ADR_TGM, 32'h0, q2);
		chk("bad tgm no swap", q, q2);
		chk("bad tgm state", 32'h0, {30'h0, st});
		sbm_far_model_inst.send(SBM_TGM_PRM, 8'h20, 1'b1);
		wb(1'b0, SBM_ADR_TGM, 32'h0, q2);
		chk("good prm swap", 32'h1, (q ^ q2) & 32'h1);
		chk("await config", 32'h1, {30'h0, st});
		wb(1'b1, SBM_ADR_AUX_SEL, 32'h2, q);
		sbm_far_model_inst.send(SBM_TGM_CFG, 8'h30, 1'b1);
		@(posedge clk);
		chk("aux2 cfg fits", 32'h0, {31'h0, no_res});
		wb(1'b1, SBM_ADR_AUX_SEL, 32'h1, q);
		wb(1'b0, SBM_ADR_TGM, 32'h0, q);
		sbm_far_model_inst.send(SBM_TGM_PRM, 8'h30, 1'b1);
		@(posedge clk);
		chk("aux2 prm fits", 32'h0, {31'h0, no_res});
		wb(1'b0, SBM_ADR_TGM, 32'h0, q2);
		chk("long prm swap", 32'h1, (q ^ q2) & 32'h1);
	endtask
	task automatic t_state;
		pulse(3);
		chk("exchange state", 32'h2, {30'h0, st});
		chk("sap exchange", 32'h3FF, {22'h0, sap});
		pulse(4);
		chk("back to prm", 32'h0, {30'h0, st});
		chk("sap gated", 32'h3C6, {22'h0, sap});
	endtask
	task automatic t_addr;
		wb(1'b1, SBM_ADR_CTRL, 32'h3, q);
		wb(1'b1, SBM_ADR_ADDR, 32'h12AB, q);
		wb(1'b0, SBM_ADR_ADDR, 32'h0, q);
		chk("addr 4k read", 32'hAC2, q);
		chk("addr 4k port", 32'hAC2, {20'h0, ram});
		wb(1'b1, SBM_ADR_CTRL, 32'h1, q);
		wb(1'b0, SBM_ADR_ADDR, 32'h0, q);
		chk("addr 2k read", 32'h56A, q);
	endtask
	task automatic t_rot;
		wb(1'b0, SBM_ADR_DOUT, 32'h0, q);
		pulse(0);
		wb(1'b1, SBM_ADR_BUFCMD, 32'h1, q2);
		wb(1'b0, SBM_ADR_DOUT, 32'h0, q2);
		chk("dout distinct", 32'h1, {31'h0, distinct(q2[5:0])});
		chk("dout user gets new", {30'h0, q[1:0]}, {30'h0, q2[3:2]});
		chk("output read user", {30'h0, q2[3:2]}, {30'h0, rout});
		wb(1'b0, SBM_ADR_DIN, 32'h0, q);
		wb(1'b1, SBM_ADR_BUFCMD, 32'h2, q2);
		pulse(1);
		wb(1'b0, SBM_ADR_DIN, 32'h0, q2);
		chk("din distinct", 32'h1, {31'h0, distinct(q2[5:0])});
		chk("din transfer gets new", {30'h0, q[3:2]}, {30'h0, q2[1:0]});
		chk("input read transfer", {30'h0, q2[1:0]}, {30'h0, rin});
	endtask
	task automatic t_diag;
		logic d0;
		d0 = diag;
		wb(1'b1, SBM_ADR_BUFCMD, 32'h4, q);
		pulse(2);
		chk("diag swapped", {31'h0, ~d0}, {31'h0, diag});
	endtask
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		ev = 5'h00;
		bad_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_sap;
		t_tgm;
		t_state;
		t_addr;
		t_rot;
		t_diag;
		end_sim;
	end
endmodule
`default_nettype wire
